/* hdl/gpio_pkg.sv */
// constants for the general purpose io port
package gpio_pkg;
  localparam int  PORT_W      = 8;
  localparam int  ADDR_W      = 16;
  localparam int  PAGE_LO     = 8;
  localparam int  SYSCFG_PAGE_BIT = 3;
  localparam logic [7:0] DIR_OFS  = 8'h00;
  localparam logic [7:0] DATA_OFS = 8'h01;
  localparam logic [7:0] DIR_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] UPPER_ZERO = 8'h00;
endpackage

/* hdl/gpio_sync.sv */
// two flop synchroniser, one per pin
`timescale 1ns/10ps
module gpio_sync #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule

/* hdl/gpio_port.sv */
// general purpose io port: direction and data registers, pin drive
// What this block does
// - a direction register picks input or output for every pin.
// - a data register write stores the value whatever the directions.
// - output pins drive the stored bit; input pins stay undriven.
// - a data register read returns the synchronised pin levels.
// - config bit selects 8-bit decode or requires address bits 15-8 zero.
`timescale 1ns/10ps
module gpio_port #(
  parameter int         PW   = gpio_pkg::PORT_W,
  parameter logic [7:0] BASE = 8'h00
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic [15:0]       io_addr,
  input  wire logic              io_wr,
  input  wire logic              io_rd,
  input  wire logic [PW-1:0]     io_wdata,
  output logic      [PW-1:0]     io_rdata,
  input  wire logic [7:0]        sys_cfg,
  input  wire logic [PW-1:0]     pin_in,
  output logic      [PW-1:0]     pin_out,
  output logic      [PW-1:0]     pin_oe
);
  localparam int AW = gpio_pkg::ADDR_W;
  localparam int PL = gpio_pkg::PAGE_LO;

  // widths the logic cannot serve are refused at elaboration
  if (PW < 1 || PW > gpio_pkg::PORT_W)
  begin : g_bad_width
    $error("port width must be 1 to 8");
  end

  // page compare is one byte wide against the zero constant
  if (AW - PL != $bits(gpio_pkg::UPPER_ZERO))
  begin : g_bad_page
    $error("page field must be one byte");
  end

  // both registers must sit inside one offset byte, no wrap
  if (int'(BASE) + int'(gpio_pkg::DATA_OFS) > (1 << PL) - 1)
  begin : g_bad_base
    $error("base leaves no room for the data register");
  end

  // address decode
  logic [AW-PL-1:0] addr_hi;
  logic [PL-1:0]    addr_lo;
  logic [PL-1:0]    dir_addr;
  logic [PL-1:0]    data_addr;
  logic             page_ok;
  logic             hit_dir;
  logic             hit_data;

  // qualified strobes
  logic             wr_dir;
  logic             wr_data;
  logic             rd_dir;
  logic             rd_data;

  // registers and synced pins
  logic [PW-1:0]    dir_r;
  logic [PW-1:0]    dir_nxt;
  logic [PW-1:0]    data_r;
  logic [PW-1:0]    data_nxt;
  logic [PW-1:0]    pin_sync;

  // pins are asynchronous; two flops before reads see them
  gpio_sync #(
    .W        (PW)
  ) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // split address into page byte and offset byte
  always_comb
  begin
    addr_hi   = io_addr[AW-1:PL];
    addr_lo   = io_addr[PL-1:0];
    dir_addr  = PL'(BASE + gpio_pkg::DIR_OFS);
    data_addr = PL'(BASE + gpio_pkg::DATA_OFS);
  end

  // any page when bit set, else upper byte must be zero
  always_comb
  begin
    page_ok = 1'b0;
    if (sys_cfg[gpio_pkg::SYSCFG_PAGE_BIT])
      page_ok = 1'b1;
    else if (addr_hi == gpio_pkg::UPPER_ZERO)
      page_ok = 1'b1;
    hit_dir  = page_ok && (addr_lo == dir_addr);
    hit_data = page_ok && (addr_lo == data_addr);
  end

  // strobes only count on a hit; misses are ignored
  always_comb
  begin
    wr_dir  = io_wr && hit_dir;
    wr_data = io_wr && hit_data;
    rd_dir  = io_rd && hit_dir;
    rd_data = io_rd && hit_data;
  end

  // direction register, cleared by reset so pins come up as inputs
  always_comb
  begin
    dir_nxt = dir_r;
    if (wr_dir)
      dir_nxt = io_wdata;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dir_r <= gpio_pkg::DIR_RST[PW-1:0];
    end
    else
    begin
      dir_r <= dir_nxt;
    end
  end

  // stored whatever the directions; an input pin just hides it
  always_comb
  begin
    data_nxt = data_r;
    if (wr_data)
      data_nxt = io_wdata;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_r <= gpio_pkg::DATA_RST[PW-1:0];
    end
    else
    begin
      data_r <= data_nxt;
    end
  end

  // one cell per pin: drive value, enable and read bit side by side
  for (genvar gi = 0; gi < PW; gi++)
  begin : g_pin
    logic drv_r;
    logic drv_nxt;
    logic en_r;
    logic en_nxt;
    logic rd_r;
    logic rd_nxt;

    // next value, not register, so the pin moves on the write edge
    always_comb
    begin
      drv_nxt = data_nxt[gi];
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        drv_r <= gpio_pkg::DATA_RST[gi];
      end
      else
      begin
        drv_r <= drv_nxt;
      end
    end

    // enable low keeps an input pin undriven
    always_comb
    begin
      en_nxt = dir_nxt[gi];
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        en_r <= gpio_pkg::DIR_RST[gi];
      end
      else
      begin
        en_r <= en_nxt;
      end
    end

    // read bit zero unless a hit; pins lag two cycles behind
    always_comb
    begin
      rd_nxt = 1'b0;
      if (rd_dir)
        rd_nxt = dir_r[gi];
      else if (rd_data)
        rd_nxt = pin_sync[gi];
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        rd_r <= 1'b0;
      end
      else
      begin
        rd_r <= rd_nxt;
      end
    end

    assign pin_out[gi]  = drv_r;
    assign pin_oe[gi]   = en_r;
    assign io_rdata[gi] = rd_r;
  end
endmodule

/* test/gpio_ext_model.sv */
// pins outside the port: driven pins read back, the rest take ext
`timescale 1ns/10ps
module gpio_ext_model (input [7:0] pin_out, pin_oe, ext, output [7:0] pin_in);
  assign pin_in = pin_oe & pin_out | ~pin_oe & ext;
endmodule

/* test/gpio_port_monitor.sv */
// assertions on the io port pins and read data
`timescale 1ns/10ps
module gpio_port_monitor (
  input core_clk, rst_b, io_wr, io_rd,
  input [15:0] io_addr,
  input [7:0] io_wdata, io_rdata, sys_cfg, pin_in, pin_out, pin_oe
);
  wire h = io_addr[15:8] == 8'h00 || sys_cfg[3];
  wire w = io_wr && h && io_addr[7:1] == 7'h00;
  wire r = io_rd && h && io_addr[7:0] == 8'h01;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_dir_write: assert property (w && !io_addr[0] |=>
    pin_oe == $past(io_wdata)) else $error("dir lost");
  chk_data_write: assert property (w && io_addr[0] |=>
    pin_out == $past(io_wdata)) else $error("data lost");
  chk_pin_hold: assert property (!io_wr |=>
    $stable(pin_out) && $stable(pin_oe)) else $error("pins moved");
  // two sync flops plus the read register
  chk_pin_read: assert property (r |=>
    io_rdata == $past(pin_in, 3)) else $error("read not pins");
  chk_page_block: assert property ((io_wr || io_rd) && !h |=>
    io_rdata == 8'h00 && $stable(pin_out)) else $error("page open");
  chk_reset_in: assert property (disable iff (1'b0)
    !rst_b && $past(!rst_b) |-> pin_oe == 8'h00) else $error("driven in reset");
  cover property (r);
  cover property (w && sys_cfg[3] && io_addr[15:8] != 8'h00);
  cover property (io_rd && !h);
endmodule

/* test/gpio_port_tb_top.sv */
// bench: random direction, data and pin levels through the port
`timescale 1ns/10ps
module general_purpose_io_port_tb_top;
  logic core_clk = 0, rst_b = 0, io_wr = 0, io_rd = 0;
  logic [15:0] io_addr = '0;
  logic [7:0] io_wdata = '0, sys_cfg = '0, ext = '0, d, v, e, q[$];
  logic [7:0] io_rdata, pin_in, pin_out, pin_oe;
  int n_fail = 0, num_checks = 0, seed = 32'h84EE;
  gpio_port dut_u (.*);
  gpio_ext_model ext_u (.*);
  always #2.5 core_clk = ~core_clk;
  initial #5000 summarize(1);
  always @(posedge core_clk)
    if (io_rd)
    begin
      @(negedge core_clk);
      num_checks++;
      if (io_rdata !== q[0])
        $display("mismatch io_rdata exp %h got %h", q[0], io_rdata);
      n_fail += int'(io_rdata !== q.pop_front());
    end
  task summarize(input int f);
    n_fail += f;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task acc(input [15:0] a, input [7:0] x, input w);
    @(posedge core_clk) #1;
    {io_addr, io_wdata, io_wr, io_rd} = {a, x, w, !w};
    if (!w) q.push_back(x);
    @(posedge core_clk) #1;
    {io_wr, io_rd} = 2'h0;
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    #1 rst_b = 1;
    acc('0, '0, 0);
    repeat (8)
    begin
      {d, v, ext, sys_cfg} = $random(seed);
      e = (sys_cfg[3] ? ~v : v) & d | ext & ~d;
      acc('0, d, 1);
      acc(16'h0001, v, 1);
      acc(16'h0A01, ~v, 1);
      repeat (4) @(posedge core_clk);
      acc(16'h0A01, sys_cfg[3] ? e : '0, 0);
      acc(16'h0001, e, 0);
      $display("port test done");
    end
    summarize(0);
  end
endmodule
bind gpio_port gpio_port_monitor mon_u (.*);
